// ### src/power_alarm_pkg.sv
// shared constants and types for the power mode and alarm register bank
package power_alarm_pkg;

  // ****************************************************************
  // configuration port geometry
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int FLAG_W = 6;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_POWER_B = 12'h29a;
  localparam logic [ADDR_W-1:0] OFS_POWER_C = 12'h29b;
  localparam logic [ADDR_W-1:0] OFS_POWER_D = 12'h29c;
  localparam logic [ADDR_W-1:0] OFS_SUMMARY = 12'h2c0;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 12'h2c1;
  localparam logic [ADDR_W-1:0] OFS_MASK = 12'h2c2;

  // ****************************************************************
  // mode encodings and reset values
  // ****************************************************************
  localparam logic [DATA_W-1:0] MODE_B_REDUCED = 8'h06;
  localparam logic [DATA_W-1:0] MODE_B_FULL = 8'h0f;
  localparam logic [DATA_W-1:0] MODE_C_REDUCED = 8'h00;
  localparam logic [DATA_W-1:0] MODE_C_FULL = 8'h04;
  localparam logic [DATA_W-1:0] MODE_D_REDUCED = 8'h14;
  localparam logic [DATA_W-1:0] MODE_D_FULL = 8'h1b;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 6'h3f;
  localparam logic [DATA_W-1:0] MASK_RESET = 8'h3f;
  localparam logic [DATA_W-1:0] SUMMARY_RESET = 8'h00;

  // ****************************************************************
  // alarm flag bit positions
  // ****************************************************************
  localparam int BIT_DIV_MISMATCH = 0;
  localparam int BIT_SPARE = 1;
  localparam int BIT_REALIGN = 2;
  localparam int BIT_LINK = 3;
  localparam int BIT_PLL = 4;
  localparam int BIT_FIFO = 5;
  localparam int BIT_SUMMARY = 0;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] rdata;
  } cfg_rsp_t;

  typedef struct packed {
    logic lane_fifo_fault_flag;
    logic serializer_pll_unlock_flag;
    logic link_not_running_flag;
    logic clock_realign_flag;
    logic divider_mismatch_flag;
  } alarm_events_t;

endpackage : power_alarm_pkg

// ### src/power_mode_and_alarm_regs.sv
// power mode registers and alarm summary behind the configuration port
//
// Summary of operation
// - setting b is 8-bit rw; 0x06 reduced power, 0x0f full performance.
// - setting c is 8-bit rw; 0x00 reduced power, 0x04 full performance.
// - setting d is 8-bit rw; 0x14 reduced power, 0x1b full performance.
// - reset leaves all three settings at their full-performance codes.
// - summary bit 0 is one when any unmasked flag is set; resets zero.
// - each alarm source can be masked individually from the summary.
// - selected by software, the summary drives the status output pin.
// - latched flags reset to 0x3f, sticky, cleared by writes; 7:6 reserved.
// - writing one clears a flag bit; writing zero leaves it alone.
// - bit 5 sets on lane fifo fault, bit 4 on serializer pll unlock.
// - power-on and soft reset both set every alarm flag to one.
// - a set mask bit blocks its flag from the summary; masks reset 0x3f.
`timescale 1ns/1ns
module power_mode_and_alarm_regs (
  input wire logic clock,
  input wire logic srst,
  input wire logic soft_reset,
  input power_alarm_pkg::cfg_req_t cfg_req,
  output power_alarm_pkg::cfg_rsp_t cfg_rsp_ff,
  input power_alarm_pkg::alarm_events_t alarm_events,
  input wire logic status_pin_alarm_sel,
  input wire logic cal_status_in,
  output logic status_output_pin_ff,
  output logic [power_alarm_pkg::DATA_W-1:0] power_mode_code_b_ff,
  output logic [power_alarm_pkg::DATA_W-1:0] power_mode_code_c_ff,
  output logic [power_alarm_pkg::DATA_W-1:0] power_mode_code_d_ff,
  output logic reduced_power_ff,
  output logic alarm_summary_ff
);
  import power_alarm_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic any_reset;
  logic [DATA_W-1:0] alarm_mask_reg_ff;
  logic [FLAG_W-1:0] flags;
  logic [FLAG_W-1:0] flag_set;
  logic [FLAG_W-1:0] flag_clear;
  logic nxt_summary;
  logic [DATA_W-1:0] summary_word;
  logic [DATA_W-1:0] nxt_rdata;
  logic nxt_reduced;
  logic wr_b;
  logic wr_c;
  logic wr_d;
  logic wr_flags;
  logic wr_mask;

  // soft reset acts like the power-on reset on every register here
  assign any_reset = srst | soft_reset;

  // ****************************************************************
  // write decode
  // ****************************************************************
  // writes to the summary or to unmapped offsets fall through silently
  assign wr_b = cfg_req.wr && (cfg_req.addr == OFS_POWER_B);
  assign wr_c = cfg_req.wr && (cfg_req.addr == OFS_POWER_C);
  assign wr_d = cfg_req.wr && (cfg_req.addr == OFS_POWER_D);
  assign wr_flags = cfg_req.wr && (cfg_req.addr == OFS_FLAGS);
  assign wr_mask = cfg_req.wr && (cfg_req.addr == OFS_MASK);

  // ****************************************************************
  // power mode settings
  // ****************************************************************
  // any value is stored; keeping to the two codes is the host's duty
  always_ff @(posedge clock) begin
    if (any_reset) begin
      power_mode_code_b_ff <= MODE_B_FULL;
    end else if (wr_b) begin
      power_mode_code_b_ff <= cfg_req.wdata;
    end
  end

  // setting c
  always_ff @(posedge clock) begin
    if (any_reset) begin
      power_mode_code_c_ff <= MODE_C_FULL;
    end else if (wr_c) begin
      power_mode_code_c_ff <= cfg_req.wdata;
    end
  end

  // setting d
  always_ff @(posedge clock) begin
    if (any_reset) begin
      power_mode_code_d_ff <= MODE_D_FULL;
    end else if (wr_d) begin
      power_mode_code_d_ff <= cfg_req.wdata;
    end
  end

  // core sees reduced power only when all three agree; a mixed set,
  // which the host must avoid, falls back to full performance
  assign nxt_reduced = (power_mode_code_b_ff == MODE_B_REDUCED) &&
                       (power_mode_code_c_ff == MODE_C_REDUCED) &&
                       (power_mode_code_d_ff == MODE_D_REDUCED);

  // decoded mode, one cycle behind the settings
  always_ff @(posedge clock) begin
    if (any_reset) begin
      reduced_power_ff <= 1'b0;
    end else begin
      reduced_power_ff <= nxt_reduced;
    end
  end

  // ****************************************************************
  // alarm mask
  // ****************************************************************
  // reserved bits 7:6 are stored as written, reset zero
  always_ff @(posedge clock) begin
    if (any_reset) begin
      alarm_mask_reg_ff <= MASK_RESET;
    end else if (wr_mask) begin
      alarm_mask_reg_ff <= cfg_req.wdata;
    end
  end

  // ****************************************************************
  // latched alarm flags
  // ****************************************************************
  // event levels map onto flag positions; the spare bit has no source
  always_comb begin
    flag_set = '0;
    flag_set[BIT_FIFO] = alarm_events.lane_fifo_fault_flag;
    flag_set[BIT_PLL] = alarm_events.serializer_pll_unlock_flag;
    flag_set[BIT_LINK] = alarm_events.link_not_running_flag;
    flag_set[BIT_REALIGN] = alarm_events.clock_realign_flag;
    flag_set[BIT_DIV_MISMATCH] = alarm_events.divider_mismatch_flag;
    flag_set[BIT_SPARE] = 1'b0;
  end

  // write-one-to-clear, low six bits only
  assign flag_clear = wr_flags ? cfg_req.wdata[FLAG_W-1:0] : '0;

  // sticky storage, set wins over a simultaneous clear
  sticky_flag_bank #(
    .WIDTH(FLAG_W),
    .RESET_VALUE(FLAGS_RESET)
  ) u_flags (
    .clock(clock),
    .srst(srst),
    .soft_reset(soft_reset),
    .set_in(flag_set),
    .clear_in(flag_clear),
    .flags_ff(flags)
  );

  // ****************************************************************
  // alarm summary
  // ****************************************************************
  // combinational so a clear or mask change shows on the next read
  assign nxt_summary = |(flags & ~alarm_mask_reg_ff[FLAG_W-1:0]);

  // registered copy for the output port; the pin mux takes the combinational summary
  always_ff @(posedge clock) begin
    if (any_reset) begin
      alarm_summary_ff <= 1'b0;
    end else begin
      alarm_summary_ff <= nxt_summary;
    end
  end

  // only bit 0 carries the summary, the rest is reserved zero
  always_comb begin
    summary_word = SUMMARY_RESET;
    summary_word[BIT_SUMMARY] = nxt_summary;
  end

  // ****************************************************************
  // status output pin
  // ****************************************************************
  // pin carries either the calibration status or the alarm summary;
  // the register stage adds one cycle but keeps the pin glitch free
  always_ff @(posedge clock) begin
    if (any_reset) begin
      status_output_pin_ff <= 1'b0;
    end else if (status_pin_alarm_sel) begin
      status_output_pin_ff <= nxt_summary;
    end else begin
      status_output_pin_ff <= cal_status_in;
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  // unmapped offsets read zero; flag bits 7:6 read zero
  always_comb begin
    nxt_rdata = '0;
    unique case (cfg_req.addr)
      OFS_POWER_B: nxt_rdata = power_mode_code_b_ff;
      OFS_POWER_C: nxt_rdata = power_mode_code_c_ff;
      OFS_POWER_D: nxt_rdata = power_mode_code_d_ff;
      OFS_SUMMARY: nxt_rdata = summary_word;
      OFS_FLAGS: nxt_rdata = {2'h0, flags};
      OFS_MASK: nxt_rdata = alarm_mask_reg_ff;
      default: nxt_rdata = '0;
    endcase
  end

  // read answer one cycle after the request; rdata held until the next read, valid drops without one
  always_ff @(posedge clock) begin
    if (any_reset) begin
      cfg_rsp_ff <= '0;
    end else if (cfg_req.rd) begin
      cfg_rsp_ff.valid <= 1'b1;
      cfg_rsp_ff.rdata <= nxt_rdata;
    end else begin
      cfg_rsp_ff.valid <= 1'b0;
    end
  end

endmodule : power_mode_and_alarm_regs

// ### src/sticky_flag_bank.sv
// sticky alarm flags with write-one-to-clear and set-over-clear priority
`timescale 1ns/1ns
module sticky_flag_bank #(
  parameter int WIDTH = 6,
  parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic soft_reset,
  input wire logic [WIDTH-1:0] set_in,
  input wire logic [WIDTH-1:0] clear_in,
  output logic [WIDTH-1:0] flags_ff
);

  // ****************************************************************
  // one flop per flag
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_flag
      // both resets load the reset pattern; a set beats a clear
      always_ff @(posedge clock) begin
        if (srst || soft_reset) begin
          flags_ff[i] <= RESET_VALUE[i];
        end else if (set_in[i]) begin
          flags_ff[i] <= 1'b1;
        end else if (clear_in[i]) begin
          flags_ff[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule : sticky_flag_bank

// ### tb/power_mode_and_alarm_regs_checker.sv
// port-level assertions for the power mode and alarm register bank
`timescale 1ns/1ns
module power_mode_and_alarm_regs_checker
  import power_alarm_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic soft_reset,
  input power_alarm_pkg::cfg_req_t cfg_req,
  input power_alarm_pkg::cfg_rsp_t cfg_rsp_ff,
  input wire logic status_pin_alarm_sel,
  input wire logic cal_status_in,
  input wire logic status_output_pin_ff,
  input wire logic [DATA_W-1:0] power_mode_code_b_ff,
  input wire logic alarm_summary_ff
);
  // ****************************************************************
  // checks
  // ****************************************************************
  // both resets act alike, so either one disables the checks other than the two reset checks
  wire logic rst = srst | soft_reset;
  default clocking main_clk @(posedge clock); endclocking
  wire logic wr_b = cfg_req.wr && cfg_req.addr == OFS_POWER_B;

  property p_reset_full;
    rst |=> power_mode_code_b_ff == MODE_B_FULL;
  endproperty
  a_reset_full: assert property (p_reset_full)
    else $error("setting b not full after reset");
  property p_write_b;
    disable iff (rst) wr_b |=> power_mode_code_b_ff == $past(cfg_req.wdata);
  endproperty
  a_write_b: assert property (p_write_b)
    else $error("setting b missed a write");
  property p_keep_b;
    disable iff (rst) !wr_b |=> $stable(power_mode_code_b_ff);
  endproperty
  a_keep_b: assert property (p_keep_b)
    else $error("setting b changed without a write");
  property p_rd_valid;
    disable iff (rst) cfg_req.rd |=> cfg_rsp_ff.valid;
  endproperty
  a_rd_valid: assert property (p_rd_valid)
    else $error("read not answered next cycle");
  property p_summary_read;
    disable iff (rst) cfg_req.rd && cfg_req.addr == OFS_SUMMARY
      |=> cfg_rsp_ff.rdata[7:1] == 7'h00;
  endproperty
  a_summary_read: assert property (p_summary_read)
    else $error("summary reserved bits not zero");
  // source held steady three cycles, so pin and summary latency agree
  property p_pin_alarm;
    disable iff (rst) (status_pin_alarm_sel && $stable(alarm_summary_ff))[*3]
      |-> status_output_pin_ff == alarm_summary_ff;
  endproperty
  a_pin_alarm: assert property (p_pin_alarm)
    else $error("pin does not follow summary");
  property p_pin_cal;
    disable iff (rst) !status_pin_alarm_sel
      |=> status_output_pin_ff == $past(cal_status_in);
  endproperty
  a_pin_cal: assert property (p_pin_cal)
    else $error("pin does not follow cal status");
  property p_reset_summary;
    rst |=> !alarm_summary_ff;
  endproperty
  a_reset_summary: assert property (p_reset_summary)
    else $error("summary set after reset");
  // no read, no answer: valid must stay a one-cycle pulse
  property p_valid_pulse;
    disable iff (rst) !cfg_req.rd |=> !cfg_rsp_ff.valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse)
    else $error("read answer valid without a read");
endmodule : power_mode_and_alarm_regs_checker

bind power_mode_and_alarm_regs power_mode_and_alarm_regs_checker chk (
  .clock(clock), .srst(srst), .soft_reset(soft_reset), .cfg_req(cfg_req),
  .cfg_rsp_ff(cfg_rsp_ff), .status_pin_alarm_sel(status_pin_alarm_sel),
  .cal_status_in(cal_status_in),
  .status_output_pin_ff(status_output_pin_ff),
  .power_mode_code_b_ff(power_mode_code_b_ff),
  .alarm_summary_ff(alarm_summary_ff));

// ### tb/test_power_mode_and_alarm_regs.sv
// self-checking bench for the power mode and alarm register bank
`timescale 1ns/1ns
module test_power_mode_and_alarm_regs;
  import power_alarm_pkg::*;
  logic clock, srst, soft_reset, sel, cal_in, pin, red, summ;
  cfg_req_t req;
  cfg_rsp_t rsp;
  alarm_events_t ev;
  logic [DATA_W-1:0] cb, cc, cd, m_b, m_c, m_d, m_mask;
  logic [FLAG_W-1:0] m_flags;
  logic [ADDR_W-1:0] ofs [7];
  int err_total, n_compared;

  power_mode_and_alarm_regs dut (.clock(clock), .srst(srst),
    .soft_reset(soft_reset), .cfg_req(req), .cfg_rsp_ff(rsp),
    .alarm_events(ev), .status_pin_alarm_sel(sel), .cal_status_in(cal_in),
    .status_output_pin_ff(pin), .power_mode_code_b_ff(cb),
    .power_mode_code_c_ff(cc), .power_mode_code_d_ff(cd),
    .reduced_power_ff(red), .alarm_summary_ff(summ));

  // ****************************************************************
  // model and tasks
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [7:0] exp_of(input logic [11:0] a);
    case (a)
      OFS_POWER_B: return m_b;
      OFS_POWER_C: return m_c;
      OFS_POWER_D: return m_d;
      OFS_SUMMARY: return {7'h00, |(m_flags & ~m_mask[5:0])};
      OFS_FLAGS: return {2'b00, m_flags};
      OFS_MASK: return m_mask;
      default: return 8'h00;
    endcase
  endfunction : exp_of

  task automatic model_reset();
    m_b = MODE_B_FULL;
    m_c = MODE_C_FULL;
    m_d = MODE_D_FULL;
    m_flags = FLAGS_RESET;
    m_mask = MASK_RESET;
  endtask : model_reset

  // request is left up; the next task or outs() replaces it
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clock);
    case (a)
      OFS_POWER_B: m_b = d;
      OFS_POWER_C: m_c = d;
      OFS_POWER_D: m_d = d;
      OFS_FLAGS: m_flags &= ~d[5:0];
      OFS_MASK: m_mask = d;
      default: ;
    endcase
  endtask : wr

  task automatic rd(input logic [11:0] a);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clock);
    check(rsp.valid, 1'b1);
    check(rsp.rdata, exp_of(a));
  endtask : rd

  // events last one cycle so no stale write repeats meanwhile
  task automatic evt(input logic [4:0] e);
    req = '0;
    ev = e;
    @(negedge clock);
    ev = '0;
    m_flags |= {e[4:1], 1'b0, e[0]};
  endtask : evt

  // event and clear in one cycle: the set must win; write left up
  task automatic evt_clr(input logic [4:0] e, input logic [7:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: OFS_FLAGS, wdata: d};
    ev = e;
    @(negedge clock);
    ev = '0;
    m_flags &= ~d[5:0];
    m_flags |= {e[4:1], 1'b0, e[0]};
  endtask : evt_clr

  task automatic outs();
    req = '0;
    repeat (3) @(negedge clock);
    check(rsp.valid, 1'b0);
    check(cb, m_b);
    check(cc, m_c);
    check(cd, m_d);
    check(red, m_b == 8'h06 && m_c == 8'h00 && m_d == 8'h14);
    check(summ, exp_of(OFS_SUMMARY));
    check(pin, sel ? exp_of(OFS_SUMMARY) : cal_in);
  endtask : outs

  task automatic sweep();
    foreach (ofs[i]) rd(ofs[i]);
    outs();
  endtask : sweep

  task automatic complete_run();
    if (err_total == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  // ****************************************************************
  // clock, watchdog and sequence
  // ****************************************************************
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    repeat (100000) @(posedge clock);
    err_total++;
    $display("ERROR %0t run did not finish", $time);
    complete_run();
  end

  initial begin
    err_total = 0;
    n_compared = 0;
    {srst, soft_reset, sel, cal_in} = 4'h8;
    req = '0;
    ev = '0;
    ofs = '{OFS_POWER_B, OFS_POWER_C, OFS_POWER_D, OFS_SUMMARY, OFS_FLAGS,
      OFS_MASK, 12'h2c3};
    void'($urandom(32'hc238));
    model_reset();
    repeat (16) @(negedge clock);
    srst = 1'b0;
    sweep();
    // only defined codes, all together, enables already clear
    wr(OFS_POWER_B, MODE_B_REDUCED);
    wr(OFS_POWER_C, MODE_C_REDUCED);
    wr(OFS_POWER_D, MODE_D_REDUCED);
    sweep();
    wr(OFS_POWER_C, MODE_C_FULL);
    outs();
    // back to full; calibration is the host's next step
    wr(OFS_POWER_B, MODE_B_FULL);
    wr(OFS_POWER_D, MODE_D_FULL);
    wr(OFS_FLAGS, 8'h00);
    sweep();
    wr(OFS_FLAGS, 8'h3f);
    wr(OFS_SUMMARY, 8'hff);
    wr(12'h2c3, 8'hff);
    sweep();
    sel = 1'b1;
    // one source unmasked at a time; bit 1 has no source
    for (int i = 0; i < 6; i++) begin
      wr(OFS_MASK, 8'h3f ^ (8'h01 << i));
      evt(5'h1f);
      wr(OFS_SUMMARY, 8'h00);
      sweep();
      wr(OFS_FLAGS, 8'h01 << i);
      sweep();
    end
    for (int k = 0; k < 40; k++) begin
      sel = 1'($urandom);
      cal_in = 1'($urandom);
      evt(5'($urandom));
      wr(OFS_FLAGS, 8'($urandom));
      wr(OFS_MASK, 8'($urandom));
      evt_clr(5'($urandom), 8'($urandom));
      sweep();
    end
    wr(OFS_POWER_B, MODE_B_REDUCED);
    wr(OFS_MASK, 8'h00);
    req = '0;
    soft_reset = 1'b1;
    @(negedge clock);
    soft_reset = 1'b0;
    model_reset();
    sweep();
    complete_run();
  end
endmodule : test_power_mode_and_alarm_regs
